//--- pkg/ttcs_regs.vh
`ifndef TTCS_REGS_VH
`define TTCS_REGS_VH

// register indices as printed; byte address is four times the index
`define TTCS_IDX_TX_BACKPLANE 8'h05
`define TTCS_IDX_TX_TIMING 8'h07
`define TTCS_IDX_CLOCK_STATUS 8'h10
`define TTCS_ADDR_W 8

// transmit timing select fields
`define TTCS_BIT_BP_FAST 7
`define TTCS_BIT_LINE_FAST 6
`define TTCS_BIT_FIFO_HI 5
`define TTCS_BIT_FIFO_LO 4
`define TTCS_BIT_PLL_HI 3
`define TTCS_BIT_PLL_LO 2
`define TTCS_BIT_SRC_INPUT 1
`define TTCS_BIT_SRC_OVERRIDE 0

// transmit backplane options field
`define TTCS_BIT_TX_SOURCE 3

`define TTCS_RST_TX_TIMING 8'h00
`define TTCS_RST_TX_BACKPLANE 8'h00

// pll reference choices
`define TTCS_PLL_TX_CLOCK 2'b00
`define TTCS_PLL_BACKPLANE 2'b01
`define TTCS_PLL_RECOVERED 2'b10
`define TTCS_PLL_TX_INPUT 2'b11

// dividers
`define TTCS_BP_DIVIDE 2
`define TTCS_SMOOTH_DIVIDE 8
`define TTCS_DIV8_W 3

`define TTCS_RESP_OKAY 2'b00
`define TTCS_RESP_SLVERR 2'b10

`endif

//--- rtl/ttcs_top.v
// Operation
// - backplane select 1: backplane blocks clocked by external fast clock divided by two.
// - backplane select 0: backplane blocks use the clock picked by line select (external fast clock or attenuator smooth 16.384MHz).
// - line select 1: line blocks use external fast clock directly, at 16.384MHz.
// - line select 0: line blocks use the attenuator smooth 16.384MHz clock.
// - fifo select high 1: fifo output uses attenuator input clock, no attenuation.
// - fifo select high 0, low 1: fifo output uses transmit clock input.
// - both fifo selects 0: fifo output uses internal smooth 2.048MHz clock.
// - pll reference 00 transmitter clock, 01 backplane, 10 recovered, 11 transmit input.
// - both source bits 0: internal smooth clocks come from the attenuator.
// - override only: 16.384 is transmit input, 2.048 is that divided by eight.
// - both source bits 1: 16.384 is external fast clock, 2.048 that over eight.
// - reset clears the whole transmit timing register to zero.
// - transmitter clock is recovered clock when backplane register source bit 3 is 1, else backplane clock.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "ttcs_regs.vh"

module ttcs_top #(
    parameter BP_DIVIDE = `TTCS_BP_DIVIDE,
    parameter SMOOTH_DIVIDE = `TTCS_SMOOTH_DIVIDE
) (
    input wire aclk,
    input wire aresetn,
    input wire clk_en,
    input wire [31:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire external_fast_clock,
    input wire backplane_transmit_clock,
    input wire recovered_receive_clock,
    input wire transmit_clock_input,
    input wire attenuator_input_clock,
    input wire attenuator_smooth_2m,
    input wire attenuator_smooth_16m,
    output reg backplane_fast_clock,
    output reg line_fast_clock,
    output reg fifo_out_clock,
    output reg pll_reference_clock,
    output reg transmitter_clock,
    output reg internal_smooth_2m,
    output reg internal_smooth_16m
);

    // the bit fields are fixed by the register layout; the divide parameters only record the ratios

    function rise;
        input cur;
        input prev;
        begin
            rise = cur & ~prev;
        end
    endfunction

    function [`TTCS_DIV8_W-1:0] div_step;
        input [`TTCS_DIV8_W-1:0] cnt;
        input edge_seen;
        begin
            if (edge_seen)
                div_step = cnt + 1'b1;
            else
                div_step = cnt;
        end
    endfunction

    function [`TTCS_ADDR_W-1:0] word_index;
        input [31:0] addr;
        begin
            word_index = addr[`TTCS_ADDR_W+1:2];
        end
    endfunction

    function mapped;
        input [31:0] addr;
        reg [`TTCS_ADDR_W-1:0] idx;
        begin
            idx = word_index(addr);
            mapped = (addr[31:`TTCS_ADDR_W+2] == 0) && ((idx == `TTCS_IDX_TX_TIMING)
                || (idx == `TTCS_IDX_TX_BACKPLANE) || (idx == `TTCS_IDX_CLOCK_STATUS));
        end
    endfunction

    reg [7:0] tx_timing_reg;
    reg tx_source_reg;
    reg [31:0] aw_addr_reg;
    reg aw_full_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg w_full_reg;

    reg external_fast_clock_prev_reg;
    reg transmit_clock_input_prev_reg;
    reg external_fast_clock_half_reg;
    reg [`TTCS_DIV8_W-1:0] external_fast_clock_div_reg;
    reg [`TTCS_DIV8_W-1:0] transmit_clock_input_div_reg;

    wire bp_fast_sel = tx_timing_reg[`TTCS_BIT_BP_FAST];
    wire line_fast_sel = tx_timing_reg[`TTCS_BIT_LINE_FAST];
    wire fifo_sel_hi = tx_timing_reg[`TTCS_BIT_FIFO_HI];
    wire fifo_sel_lo = tx_timing_reg[`TTCS_BIT_FIFO_LO];
    wire [1:0] pll_sel = {tx_timing_reg[`TTCS_BIT_PLL_HI], tx_timing_reg[`TTCS_BIT_PLL_LO]};
    wire src_input = tx_timing_reg[`TTCS_BIT_SRC_INPUT];
    wire src_override = tx_timing_reg[`TTCS_BIT_SRC_OVERRIDE];

    wire external_fast_clock_rise = rise(external_fast_clock, external_fast_clock_prev_reg);
    wire transmit_clock_input_rise = rise(transmit_clock_input, transmit_clock_input_prev_reg);

    reg smooth_2m_next;
    reg smooth_16m_next;
    reg tx_clock_next;
    reg bp_fast_next;
    reg line_fast_next;
    reg fifo_out_next;
    reg pll_ref_next;

    always @*
    begin
        // the unsupported input-only combination falls back to the attenuator clocks
        smooth_2m_next = attenuator_smooth_2m;
        smooth_16m_next = attenuator_smooth_16m;
        if (!src_input && src_override)
        begin
            smooth_16m_next = transmit_clock_input;
            smooth_2m_next = transmit_clock_input_div_reg[`TTCS_DIV8_W-1];
        end
        else if (src_input && src_override)
        begin
            smooth_16m_next = external_fast_clock;
            smooth_2m_next = external_fast_clock_div_reg[`TTCS_DIV8_W-1];
        end

        tx_clock_next = tx_source_reg ? recovered_receive_clock : backplane_transmit_clock;

        if (bp_fast_sel)
            bp_fast_next = external_fast_clock_half_reg;
        else
            bp_fast_next = line_fast_next;

        if (line_fast_sel)
            line_fast_next = external_fast_clock;
        else
            line_fast_next = attenuator_smooth_16m;

        if (fifo_sel_hi)
            fifo_out_next = attenuator_input_clock;
        else if (fifo_sel_lo)
            fifo_out_next = transmit_clock_input;
        else
            fifo_out_next = smooth_2m_next;

        case (pll_sel)
            `TTCS_PLL_TX_CLOCK: pll_ref_next = tx_clock_next;
            `TTCS_PLL_BACKPLANE: pll_ref_next = backplane_transmit_clock;
            `TTCS_PLL_RECOVERED: pll_ref_next = recovered_receive_clock;
            `TTCS_PLL_TX_INPUT: pll_ref_next = transmit_clock_input;
            default: pll_ref_next = tx_clock_next;
        endcase
    end

    // clock dividers work on sampled edges, so every derived clock trails its source by one aclk
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            external_fast_clock_prev_reg <= 1'b0;
            transmit_clock_input_prev_reg <= 1'b0;
            external_fast_clock_half_reg <= 1'b0;
            external_fast_clock_div_reg <= {`TTCS_DIV8_W{1'b0}};
            transmit_clock_input_div_reg <= {`TTCS_DIV8_W{1'b0}};
        end
        else if (clk_en)
        begin
            external_fast_clock_prev_reg <= external_fast_clock;
            transmit_clock_input_prev_reg <= transmit_clock_input;
            if (external_fast_clock_rise)
                external_fast_clock_half_reg <= ~external_fast_clock_half_reg;
            external_fast_clock_div_reg <= div_step(external_fast_clock_div_reg, external_fast_clock_rise);
            transmit_clock_input_div_reg <= div_step(transmit_clock_input_div_reg, transmit_clock_input_rise);
        end
    end

    // selected clocks leave through flip-flops, trading one aclk of delay for glitch-free outputs
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            backplane_fast_clock <= 1'b0;
            line_fast_clock <= 1'b0;
            fifo_out_clock <= 1'b0;
            pll_reference_clock <= 1'b0;
            transmitter_clock <= 1'b0;
            internal_smooth_2m <= 1'b0;
            internal_smooth_16m <= 1'b0;
        end
        else if (clk_en)
        begin
            backplane_fast_clock <= bp_fast_next;
            line_fast_clock <= line_fast_next;
            fifo_out_clock <= fifo_out_next;
            pll_reference_clock <= pll_ref_next;
            transmitter_clock <= tx_clock_next;
            internal_smooth_2m <= smooth_2m_next;
            internal_smooth_16m <= smooth_16m_next;
        end
    end

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
    wire [`TTCS_ADDR_W-1:0] wr_idx = word_index(aw_addr_reg);
    wire [`TTCS_ADDR_W-1:0] rd_idx = word_index(s_axi_araddr);

    reg [31:0] rd_word;

    always @*
    begin
        rd_word = 32'h0000_0000;
        case (rd_idx)
            `TTCS_IDX_TX_TIMING: rd_word = {24'h00_0000, tx_timing_reg};
            `TTCS_IDX_TX_BACKPLANE: rd_word = {28'h000_0000, tx_source_reg, 3'b000};
            `TTCS_IDX_CLOCK_STATUS: rd_word = {16'h0000, 2'b00, external_fast_clock_div_reg, transmit_clock_input_div_reg,
                external_fast_clock_half_reg, backplane_fast_clock, line_fast_clock, fifo_out_clock,
                pll_reference_clock, transmitter_clock, internal_smooth_2m, internal_smooth_16m};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // the reset word is held in a net so that only its one defined bit is taken
    wire [7:0] backplane_reset_value = `TTCS_RST_TX_BACKPLANE;

    // readies are one-cycle pulses; clk_en must stay high while a bus transfer is open
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_addr_reg <= 32'h0000_0000;
            aw_full_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            w_full_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else if (clk_en)
        begin
            s_axi_awready <= s_axi_awvalid && !s_axi_awready && !aw_full_reg;
            s_axi_wready <= s_axi_wvalid && !s_axi_wready && !w_full_reg;
            if (aw_take)
            begin
                aw_addr_reg <= s_axi_awaddr;
                aw_full_reg <= 1'b1;
            end
            if (w_take)
            begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_full_reg <= 1'b1;
            end
            if (do_write)
            begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
            end
        end
    end

    // a write lands in the cycle its response rises, so a read after bvalid sees the new value
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tx_timing_reg <= `TTCS_RST_TX_TIMING;
            tx_source_reg <= backplane_reset_value[`TTCS_BIT_TX_SOURCE];
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TTCS_RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_addr_reg) ? `TTCS_RESP_OKAY : `TTCS_RESP_SLVERR;
                if (mapped(aw_addr_reg) && w_strb_reg[0])
                begin
                    if (wr_idx == `TTCS_IDX_TX_TIMING)
                        tx_timing_reg <= w_data_reg[7:0];
                    if (wr_idx == `TTCS_IDX_TX_BACKPLANE)
                        tx_source_reg <= w_data_reg[`TTCS_BIT_TX_SOURCE];
                end
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // no new read is accepted until the previous data has been taken
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `TTCS_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (ar_take)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= mapped(s_axi_araddr) ? `TTCS_RESP_OKAY : `TTCS_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule
`default_nettype wire

//--- tb/transmit_timing_clock_select_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "ttcs_regs.vh"
`define ttcs_chk(n, e, s) \
    begin \
        checks_done++; \
        if ((e) !== (s)) \
        begin \
            error_cnt++; \
            $display("CHECK FAILED %s expected %0h seen %0h", n, e, s); \
        end \
    end
module transmit_timing_clock_select_tb_top;
    localparam logic [31:0] A_TT = {22'h0, `TTCS_IDX_TX_TIMING, 2'b00};
    localparam logic [31:0] A_BP = {22'h0, `TTCS_IDX_TX_BACKPLANE, 2'b00};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic clk_en = 1'b1;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic external_fast_clock = 1'b0, backplane_transmit_clock = 1'b0, recovered_receive_clock = 1'b0;
    logic transmit_clock_input = 1'b0, attenuator_input_clock = 1'b0;
    logic attenuator_smooth_2m = 1'b0, attenuator_smooth_16m = 1'b0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic backplane_fast_clock, line_fast_clock, fifo_out_clock, pll_reference_clock;
    wire logic transmitter_clock, internal_smooth_2m, internal_smooth_16m;
    int error_cnt = 0;
    int checks_done = 0;
    ttcs_top u_dut (.*);
    always #20 aclk = ~aclk;
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        repeat (50)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        if (!s_axi_bvalid)
        begin
            error_cnt++;
            end_sim();
        end
        else
            `ttcs_chk("bresp", er, s_axi_bresp)
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        repeat (50)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        if (!s_axi_rvalid)
        begin
            error_cnt++;
            end_sim();
        end
        else
        begin
            `ttcs_chk("rdata", e, s_axi_rdata)
            `ttcs_chk("rresp", er, s_axi_rresp)
        end
    endtask
    // order: bp, line, fifo, pll, tx, smooth fast; inputs c = {s16, s2, ain, tin, rcv, btc, ext}
    function automatic logic [5:0] exp_out(input logic [31:0] t, input logic [31:0] b, input logic [6:0] c);
        logic txs;
        logic [3:0] pl;
        txs = b[3] ? c[2] : c[1];
        pl = {c[3], c[2], c[1], txs};
        return {t[6] ? c[0] : c[6], t[6] ? c[0] : c[6], t[5] ? c[4] : t[4] ? c[3] : c[5], pl[t[3:2]], txs,
            t[1:0] == 2'b11 ? c[0] : t[1:0] == 2'b01 ? c[3] : c[6]};
    endfunction
    task automatic sel_run(input int i);
        logic [31:0] d;
        logic [31:0] e;
        logic [6:0] q;
        logic [6:0] hist[$];
        logic [5:0] m;
        d = $urandom;
        e = $urandom;
        d[5:2] = i[3:0];
        if (d[1:0] == 2'b10) d[1] = 1'b0;
        wr(A_BP, e, 4'hF, `TTCS_RESP_OKAY);
        wr(A_TT, d, 4'hF, `TTCS_RESP_OKAY);
        rd(A_BP, e & 32'h0000_0008, `TTCS_RESP_OKAY);
        rd(A_TT, d & 32'h0000_00FF, `TTCS_RESP_OKAY);
        m = {!d[7], 1'b1, d[5:4] != 2'b00 || d[1:0] == 2'b00, 3'h7};
        // the model queue holds the inputs until the registered outputs show them two edges later
        for (int k = 0; k < 24; k++)
        begin
            @(posedge aclk);
            if (hist.size() > 1)
            begin
                q = hist.pop_front();
                `ttcs_chk("clk_sel", exp_out(d, e, q) & m, {backplane_fast_clock, line_fast_clock,
                    fifo_out_clock, pll_reference_clock, transmitter_clock, internal_smooth_16m} & m)
            end
            q = 7'($urandom);
            hist.push_back(q);
            {attenuator_smooth_16m, attenuator_smooth_2m, attenuator_input_clock, transmit_clock_input,
                recovered_receive_clock, backplane_transmit_clock, external_fast_clock} <= q;
        end
    endtask
    task automatic div_run(input logic [7:0] md);
        int a;
        int b;
        logic p2;
        logic pb;
        external_fast_clock <= 1'b0;
        transmit_clock_input <= 1'b0;
        wr(A_TT, {24'h0, md}, 4'hF, `TTCS_RESP_OKAY);
        repeat (8) @(posedge aclk);
        a = 0;
        b = 0;
        p2 = internal_smooth_2m;
        pb = backplane_fast_clock;
        // 64 source rises, period of four bus clocks, then a tail for the divider latency
        for (int j = 0; j < 262; j++)
        begin
            @(posedge aclk);
            a += int'(internal_smooth_2m && !p2);
            b += int'(backplane_fast_clock != pb);
            p2 = internal_smooth_2m;
            pb = backplane_fast_clock;
            external_fast_clock <= j < 256 && j[1];
            transmit_clock_input <= j < 256 && j[1];
        end
        `ttcs_chk("div8", 8, a)
        `ttcs_chk("div2", 64, b)
    endtask
    initial
    begin
        void'($urandom(32'h9219_9279));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_TT, 32'h0, `TTCS_RESP_OKAY);
        rd(A_BP, 32'h0, `TTCS_RESP_OKAY);
        $display("test reset values done");
        for (int i = 0; i < 16; i++)
            sel_run(i);
        $display("test clock selection done");
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(A_TT, 32'h0, `TTCS_RESP_OKAY);
        wr(A_TT, 32'h0000_00A5, 4'hE, `TTCS_RESP_OKAY);
        rd(A_TT, 32'h0, `TTCS_RESP_OKAY);
        wr(32'h0000_0020, 32'hFFFF_FFFF, 4'hF, `TTCS_RESP_SLVERR);
        rd(32'h0000_0020, 32'h0, `TTCS_RESP_SLVERR);
        wr(32'h0000_041C, 32'h0000_00FF, 4'hF, `TTCS_RESP_SLVERR);
        rd(A_TT, 32'h0, `TTCS_RESP_OKAY);
        $display("test refusals done");
        div_run(8'h81);
        div_run(8'h83);
        $display("test dividers done");
        end_sim();
    end
endmodule
`default_nettype wire

//--- tb/ttcs_asserts.sv
`timescale 1ns/1ns
`default_nettype none
`include "ttcs_regs.vh"
module ttcs_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic external_fast_clock,
    input wire logic backplane_transmit_clock,
    input wire logic recovered_receive_clock,
    input wire logic transmit_clock_input,
    input wire logic attenuator_input_clock,
    input wire logic attenuator_smooth_2m,
    input wire logic attenuator_smooth_16m,
    input wire logic backplane_fast_clock,
    input wire logic line_fast_clock,
    input wire logic fifo_out_clock,
    input wire logic pll_reference_clock,
    input wire logic transmitter_clock,
    input wire logic internal_smooth_2m,
    input wire logic internal_smooth_16m
);
    logic [7:0] tt_reg;
    logic bp_reg;
    logic [2:0] quiet_reg;
    wire hit = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
    // selections are only judged once the shadow copy has been settled for a while
    wire ok = quiet_reg == 3'h7;
    wire [1:0] sm = tt_reg[1:0];
    wire txs = bp_reg ? recovered_receive_clock : backplane_transmit_clock;
    wire lsrc = tt_reg[6] ? external_fast_clock : attenuator_smooth_16m;
    wire [3:0] pll_src = {transmit_clock_input, recovered_receive_clock, backplane_transmit_clock, txs};
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tt_reg <= 8'h00;
            bp_reg <= 1'b0;
            quiet_reg <= 3'h0;
        end
        else
        begin
            if (hit && s_axi_awaddr == {22'h0, `TTCS_IDX_TX_TIMING, 2'b00})
                tt_reg <= s_axi_wdata[7:0];
            if (hit && s_axi_awaddr == {22'h0, `TTCS_IDX_TX_BACKPLANE, 2'b00})
                bp_reg <= s_axi_wdata[3];
            if (hit || !clk_en)
                quiet_reg <= 3'h0;
            else if (quiet_reg != 3'h7)
                quiet_reg <= quiet_reg + 3'h1;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_reset;
        $rose(aresetn) |-> !line_fast_clock && !fifo_out_clock && !pll_reference_clock && !internal_smooth_16m;
    endproperty
    property p_line;
        ok |-> line_fast_clock == $past(lsrc);
    endproperty
    property p_bp_smooth;
        ok && !tt_reg[7] |-> backplane_fast_clock == $past(lsrc);
    endproperty
    property p_bp_half;
        ok && tt_reg[7] |-> (backplane_fast_clock != $past(backplane_fast_clock))
            == ($past(external_fast_clock, 2) && !$past(external_fast_clock, 3));
    endproperty
    property p_fifo;
        ok && (tt_reg[5] || tt_reg[4] || sm == 2'b00) |-> fifo_out_clock
            == $past(tt_reg[5] ? attenuator_input_clock : tt_reg[4] ? transmit_clock_input : attenuator_smooth_2m);
    endproperty
    property p_pll;
        ok |-> pll_reference_clock == $past(pll_src[tt_reg[3:2]]);
    endproperty
    property p_tx;
        ok |-> transmitter_clock == $past(txs);
    endproperty
    property p_s16;
        ok |-> internal_smooth_16m
            == $past(sm == 2'b11 ? external_fast_clock : sm == 2'b01 ? transmit_clock_input : attenuator_smooth_16m);
    endproperty
    property p_s2m;
        ok && sm == 2'b00 |-> internal_smooth_2m == $past(attenuator_smooth_2m);
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
    a_line: assert property (p_line) else $error("line clock source wrong");
    a_bp_smooth: assert property (p_bp_smooth) else $error("backplane clock source wrong");
    a_bp_half: assert property (p_bp_half) else $error("backplane half rate wrong");
    a_fifo: assert property (p_fifo) else $error("fifo output clock wrong");
    a_pll: assert property (p_pll) else $error("pll reference wrong");
    a_tx: assert property (p_tx) else $error("transmitter clock wrong");
    a_s16: assert property (p_s16) else $error("smooth fast clock wrong");
    a_s2m: assert property (p_s2m) else $error("smooth slow clock wrong");
    c_half: cover property (ok && tt_reg[7]);
    c_ext: cover property (ok && sm == 2'b11);
    c_rst: cover property ($rose(aresetn));
endmodule
bind ttcs_top ttcs_asserts u_chk (.*);
`default_nettype wire
